// >>> logic/pifb_flag_bank.sv
// Purpose: six peripheral interrupt flag registers with enables, priorities
// Assumes: event inputs synchronous to clk; AXI4-Lite slave, one clock
// Notes:   irq_high and irq_low are registered requests to the CPU core
`default_nettype none

module pifb_flag_bank
  import pifb_pkg::*;
#(
  parameter bit SMALL_MEM = 1'b0
)
(
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output var  logic                     s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output var  logic                     s_axi_wready,
  output var  logic [1:0]               s_axi_bresp,
  output var  logic                     s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [ADDR_W-1:0]        s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output var  logic                     s_axi_arready,
  output var  logic [31:0]              s_axi_rdata,
  output var  logic [1:0]               s_axi_rresp,
  output var  logic                     s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic [NUM_REGS-1:0][7:0] evt_flags,
  input  wire logic                     serial1_rx_full,
  input  wire logic                     serial1_tx_empty,
  input  wire logic                     serial2_rx_full,
  input  wire logic                     serial2_tx_empty,
  output var  logic                     irq_high,
  output var  logic                     irq_low
);

  // ****************************************
  // helpers
  // ****************************************
  localparam logic [NUM_REGS*8-1:0] IMPL = SMALL_MEM ? IMPL_SMALL : IMPL_FULL;

  function automatic logic [7:0] impl_bits(input int idx);
    impl_bits = IMPL[idx*8 +: 8];
  endfunction

  function automatic logic [7:0] ro_bits(input int idx);
    ro_bits = RO_MASK[idx*8 +: 8];
  endfunction

  // decode a bank: hit flag and word index within the bank
  function automatic logic bank_hit(input logic [ADDR_W-1:0] a,
                                    input logic [7:0]        base);
    logic [7:0] d;
    d = a - base;
    bank_hit = (a >= base) && (d < 8'(NUM_REGS * 4)) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [IDX_W-1:0] bank_idx(input logic [ADDR_W-1:0] a,
                                                input logic [7:0]        base);
    logic [7:0] d;
    d = a - base;
    bank_idx = d[IDX_W+1:2];
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [7:0]        flag_ff     [NUM_REGS];
  logic [7:0]        nxt_flag    [NUM_REGS];
  logic [7:0]        en_ff       [NUM_REGS];
  logic [7:0]        nxt_en      [NUM_REGS];
  logic [7:0]        prio_ff     [NUM_REGS];
  logic [7:0]        nxt_prio    [NUM_REGS];
  logic [2:0]        ctrl_ff;
  logic [2:0]        nxt_ctrl;

  logic              aw_ok_ff;
  logic              nxt_aw_ok;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [ADDR_W-1:0] nxt_awaddr;
  logic              w_ok_ff;
  logic              nxt_w_ok;
  logic [7:0]        wdata_ff;
  logic [7:0]        nxt_wdata;
  logic              wlane_ff;
  logic              nxt_wlane;
  logic              awready_ff;
  logic              nxt_awready;
  logic              wready_ff;
  logic              nxt_wready;
  logic              bvalid_ff;
  logic              nxt_bvalid;
  logic [1:0]        bresp_ff;
  logic [1:0]        nxt_bresp;

  logic              arready_ff;
  logic              nxt_arready;
  logic              rvalid_ff;
  logic              nxt_rvalid;
  logic [31:0]       rdata_ff;
  logic [31:0]       nxt_rdata;
  logic [1:0]        rresp_ff;
  logic [1:0]        nxt_rresp;

  logic              irq_high_ff;
  logic              nxt_irq_high;
  logic              irq_low_ff;
  logic              nxt_irq_low;

  logic              do_wr;

  // store fires once both halves are held and no response is pending
  assign do_wr = aw_ok_ff && w_ok_ff && !bvalid_ff;

  // ****************************************
  // write channel
  // ****************************************
  // address and data are caught independently, in either order
  always_comb
  begin
    nxt_aw_ok   = aw_ok_ff;
    nxt_awaddr  = awaddr_ff;
    nxt_w_ok    = w_ok_ff;
    nxt_wdata   = wdata_ff;
    nxt_wlane   = wlane_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    if (s_axi_awvalid && awready_ff)
    begin
      nxt_aw_ok  = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff)
    begin
      nxt_w_ok  = 1'b1;
      nxt_wdata = s_axi_wdata[7:0];
      nxt_wlane = s_axi_wstrb[0];
    end
    if (do_wr)
    begin
      nxt_aw_ok  = 1'b0;
      nxt_w_ok   = 1'b0;
      nxt_bvalid = 1'b1;
      if (bank_hit(awaddr_ff, FLAG_BASE) || bank_hit(awaddr_ff, EN_BASE) ||
          bank_hit(awaddr_ff, PRIO_BASE) || awaddr_ff == CTRL_ADDR)
        nxt_bresp = RESP_OKAY;
      else
        nxt_bresp = RESP_SLVERR;
    end
    else if (bvalid_ff && s_axi_bready)
      nxt_bvalid = 1'b0;
    // one write at a time: no new address or data until the response is taken
    // readies come back at the edge that retires the response
    nxt_awready = !nxt_aw_ok && !nxt_bvalid && !(aw_ok_ff && w_ok_ff);
    nxt_wready  = !nxt_w_ok && !nxt_bvalid && !(aw_ok_ff && w_ok_ff);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_ok_ff   <= 1'b0;
      awaddr_ff  <= '0;
      w_ok_ff    <= 1'b0;
      wdata_ff   <= 8'h00;
      wlane_ff   <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end
    else
    begin
      aw_ok_ff   <= nxt_aw_ok;
      awaddr_ff  <= nxt_awaddr;
      w_ok_ff    <= nxt_w_ok;
      wdata_ff   <= nxt_wdata;
      wlane_ff   <= nxt_wlane;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
    end
  end

  // ****************************************
  // register banks
  // ****************************************
  always_comb
  begin
    logic       hit;
    logic [7:0] wm;
    logic [7:0] wv;
    hit = 1'b0;
    wm  = 8'h00;
    wv  = 8'h00;
    nxt_ctrl = ctrl_ff;
    // a write with lane 0 strobe low is answered OKAY but stores nothing
    if (do_wr && wlane_ff && awaddr_ff == CTRL_ADDR)
      nxt_ctrl = wdata_ff[2:0];
    for (int i = 0; i < NUM_REGS; i++)
    begin
      nxt_en[i]   = en_ff[i];
      nxt_prio[i] = prio_ff[i];
      if (do_wr && wlane_ff && bank_hit(awaddr_ff, EN_BASE) &&
          bank_idx(awaddr_ff, EN_BASE) == IDX_W'(i))
        nxt_en[i] = wdata_ff & impl_bits(i);
      if (do_wr && wlane_ff && bank_hit(awaddr_ff, PRIO_BASE) &&
          bank_idx(awaddr_ff, PRIO_BASE) == IDX_W'(i))
        nxt_prio[i] = wdata_ff & impl_bits(i);

      // software write stores ones and zeros alike  (see RL25)
      wm  = impl_bits(i) & ~ro_bits(i);
      hit = do_wr && wlane_ff && bank_hit(awaddr_ff, FLAG_BASE) &&
            bank_idx(awaddr_ff, FLAG_BASE) == IDX_W'(i);
      wv  = hit ? ((flag_ff[i] & ~wm) | (wdata_ff & wm)) : flag_ff[i];
      // events set regardless of any enable, and win over a clear
      // (see RL1) (see RL26) (see RL4) (see RL5) (see RL8) (see RL9)
      // (see RL10) (see RL11) (see RL12) (see RL13) (see RL14)
      // (see RL16) (see RL17) (see RL18) (see RL19) (see RL20)
      // absent positions are masked off  (see RL21) (see RL22)
      nxt_flag[i] = (wv | evt_flags[i]) & wm;
    end
    // buffer status bits follow the serial ports, not software  (see RL6) (see RL7)
    // the mirror lags its input by one edge; the port clears it by dropping the level
    nxt_flag[REG_ONE][RX_BIT]   = serial1_rx_full;
    nxt_flag[REG_ONE][TX_BIT]   = serial1_tx_empty;
    // (see RL15)
    nxt_flag[REG_THREE][RX_BIT] = serial2_rx_full;
    nxt_flag[REG_THREE][TX_BIT] = serial2_tx_empty;
  end

  // six independent flag words  (see RL3)
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        flag_ff[i] <= FLAG_RST;
        en_ff[i]   <= EN_RST;
        // absent positions stay 0, like the enable bits behind them
        prio_ff[i] <= PRIO_RST & IMPL[i*8 +: 8];
      end
      ctrl_ff <= CTRL_RST;
    end
    else
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        flag_ff[i] <= nxt_flag[i];
        en_ff[i]   <= nxt_en[i];
        prio_ff[i] <= nxt_prio[i];
      end
      ctrl_ff <= nxt_ctrl;
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  always_comb
  begin
    logic [7:0] v;
    v          = 8'h00;
    nxt_rvalid = rvalid_ff;
    // data are caught at the address handshake; later flag changes miss this read
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (s_axi_arvalid && arready_ff)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = RESP_OKAY;
      if (bank_hit(s_axi_araddr, FLAG_BASE))
        v = flag_ff[bank_idx(s_axi_araddr, FLAG_BASE)];
      else if (bank_hit(s_axi_araddr, EN_BASE))
        v = en_ff[bank_idx(s_axi_araddr, EN_BASE)];
      else if (bank_hit(s_axi_araddr, PRIO_BASE))
        v = prio_ff[bank_idx(s_axi_araddr, PRIO_BASE)];
      else if (s_axi_araddr == CTRL_ADDR)
        v = {5'h00, ctrl_ff};
      else
        nxt_rresp = RESP_SLVERR;
      nxt_rdata = {24'h000000, v};
    end
    else if (rvalid_ff && s_axi_rready)
      nxt_rvalid = 1'b0;
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= RESP_OKAY;
    end
    else
    begin
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  // ****************************************
  // interrupt requests
  // ****************************************
  always_comb
  begin
    logic any_hi;
    logic any_lo;
    logic [7:0] act;
    any_hi = 1'b0;
    any_lo = 1'b0;
    act    = 8'h00;
    for (int i = 0; i < NUM_REGS; i++)
    begin
      act    = flag_ff[i] & en_ff[i];
      any_hi = any_hi | (|(act & prio_ff[i]));
      any_lo = any_lo | (|(act & ~prio_ff[i]));
    end
    // requests are registered, so they trail a flag or enable change by one edge
    if (ctrl_ff[CTRL_PRIO_MODE])
    begin
      // priority bit picks the level; low also needs its own enable  (see RL24)
      nxt_irq_high = ctrl_ff[CTRL_GLOBAL_EN] && any_hi;
      nxt_irq_low  = ctrl_ff[CTRL_GLOBAL_EN] && ctrl_ff[CTRL_GROUP_EN] && any_lo;
    end
    else
    begin
      // all sources share one request  (see RL23)
      nxt_irq_high = ctrl_ff[CTRL_GLOBAL_EN] && ctrl_ff[CTRL_GROUP_EN] && (any_hi || any_lo);
      nxt_irq_low  = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_high_ff <= 1'b0;
      irq_low_ff  <= 1'b0;
    end
    else
    begin
      irq_high_ff <= nxt_irq_high;
      irq_low_ff  <= nxt_irq_low;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign irq_high      = irq_high_ff;
  assign irq_low       = irq_low_ff;

endmodule

`default_nettype wire

// >>> logic/pifb_pkg.sv
// Purpose: constants for the peripheral interrupt flag bank
// Assumes: 32-bit AXI4-Lite register bus, 8-bit registers in byte lane 0
// Notes:   flag, enable and priority banks are six words each
//
// Functional notes
// RL1: flags set on events regardless of enables
// RL2: software clears flag before enabling, after service
// RL3: six separate 8-bit flag registers
// RL4: host port access sets first bit 7
// RL5: conversion done sets first bit 6
// RL6: first bit 5 read-only receive full
// RL7: first bit 4 read-only transmit empty
// RL8: sync port done flags, sticky
// RL9: timer gate flags, sticky
// RL10: timer period match flags, sticky
// RL11: timer overflow flags, sticky
// RL12: oscillator fail sets second bit 7
// RL13: bus collision flags second bits 4, 3
// RL14: low voltage sets second bit 2
// RL15: third bits 5, 4 read-only serial two
// RL16: capture/compare flags set on capture or match
// RL17: channels three to ten in fourth register
// RL18: charge time and calendar flags third register
// RL19: memory write done sets sixth bit 4
// RL20: comparator flags sixth bits 2..0
// RL21: unimplemented positions read zero
// RL22: small variant lacks some channel, timer flags
// RL23: compatibility mode needs all three enables
// RL24: priority bits route to high or low
// RL25: flags reset zero, writes set or clear
// RL26: hardware set beats software clear
`default_nettype none

package pifb_pkg;

  localparam int          ADDR_W      = 8;
  localparam int          NUM_REGS    = 6;
  localparam int          IDX_W       = 3;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0]  FLAG_BASE   = 8'h00;
  localparam logic [7:0]  EN_BASE     = 8'h18;
  localparam logic [7:0]  PRIO_BASE   = 8'h30;
  localparam logic [7:0]  CTRL_ADDR   = 8'h48;

  // control word fields
  localparam int          CTRL_GLOBAL_EN = 0;
  localparam int          CTRL_GROUP_EN  = 1;
  localparam int          CTRL_PRIO_MODE = 2;
  localparam logic [2:0]  CTRL_RST    = 3'h0;

  localparam logic [7:0]  FLAG_RST    = 8'h00;
  localparam logic [7:0]  EN_RST      = 8'h00;
  localparam logic [7:0]  PRIO_RST    = 8'hFF;

  // ****************************************
  // implemented and read-only positions
  // ****************************************
  localparam logic [NUM_REGS*8-1:0] IMPL_FULL  = 48'h17_FF_FF_BF_BF_FF;
  localparam logic [NUM_REGS*8-1:0] IMPL_SMALL = 48'h17_17_3F_BF_BF_FF;
  localparam logic [NUM_REGS*8-1:0] RO_MASK    = 48'h00_00_00_30_00_30;

  // serial status positions inside registers one and three
  localparam int          RX_BIT      = 5;
  localparam int          TX_BIT      = 4;
  localparam int          REG_ONE     = 0;
  localparam int          REG_THREE   = 2;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// >>> test/pifb_flag_bank_asserts.sv
// Purpose: bus checks and request covers on the flag bank ports
// Assumes: one clock domain, ports of pifb_flag_bank only
// Notes:   attached to every flag bank instance by bind
`default_nettype none
module pifb_flag_bank_asserts
  import pifb_pkg::*;
(
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              irq_high,
  input wire logic              irq_low
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // ****************************************
  // bus answers
  // ****************************************
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_latency: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_byte_lane: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_unmapped_read: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr > CTRL_ADDR |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_ready_return: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1 (s_axi_awready && s_axi_wready))
    else $error("write readies not restored");
  a_read_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_irq_high: cover property ($rose(irq_high));
  c_irq_low: cover property ($rose(irq_low));
endmodule

bind pifb_flag_bank pifb_flag_bank_asserts i_pifb_flag_bank_asserts (.*);
`default_nettype wire

// >>> test/tb_pifb_flag_bank.sv
// Purpose: self-checking bench for the peripheral flag bank
// Assumes: AXI4-Lite master tasks, 25 MHz clock, full-size and small-memory variants
// Notes:   serial status inputs are driven directly as levels
`default_nettype none
module tb_pifb_flag_bank
  import pifb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                     clk = 1'h0, resetn = 1'h0;
  logic [ADDR_W-1:0]        s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0]              s_axi_wdata = 32'h0, s_axi_rdata, rd_val;
  logic [3:0]               s_axi_wstrb = 4'h0;
  logic                     s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic                     s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic                     serial1_rx_full = 1'h0, serial1_tx_empty = 1'h0;
  logic                     serial2_rx_full = 1'h0, serial2_tx_empty = 1'h0;
  logic [NUM_REGS-1:0][7:0] evt_flags = 48'h0;
  logic                     s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic                     irq_high, irq_low;
  logic [1:0]               s_axi_bresp, s_axi_rresp, rsp;
  int                       error_cnt = 0, n_checks = 0;
  logic                     sm_awready, sm_wready, sm_bvalid, sm_arready, sm_rvalid, sm_irq_high, sm_irq_low;
  logic [1:0]               sm_bresp, sm_rresp;
  logic [31:0]              sm_rdata, sm_val;

  pifb_flag_bank i_pifb_flag_bank (.*);

  // small-memory variant shares every input and answers in step with the full one
  pifb_flag_bank #(.SMALL_MEM(1'b1)) i_pifb_flag_bank_small (
    .clk(clk), .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(sm_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(sm_wready), .s_axi_bresp(sm_bresp), .s_axi_bvalid(sm_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(sm_arready),
    .s_axi_rdata(sm_rdata), .s_axi_rresp(sm_rresp), .s_axi_rvalid(sm_rvalid), .s_axi_rready(s_axi_rready),
    .evt_flags(evt_flags), .serial1_rx_full(serial1_rx_full), .serial1_tx_empty(serial1_tx_empty),
    .serial2_rx_full(serial2_rx_full), .serial2_tx_empty(serial2_tx_empty),
    .irq_high(sm_irq_high), .irq_low(sm_irq_low)
  );

  always #20 clk = ~clk;

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // handshakes are judged at the falling edge, where ready is settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'hF);
    logic ha, hw, hb;
    int   n;
    n = 0;
    hb = 1'h0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!hb && n < 64)
    begin
      @(negedge clk);
      n++;
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge clk);
      if (ha) s_axi_awvalid <= 1'h0;
      if (hw) s_axi_wvalid <= 1'h0;
      if (hb) s_axi_bready <= 1'h0;
    end
    chk("write answer", 32'h1, {31'h0, hb});
  endtask

  task automatic rd(input logic [7:0] a);
    logic ha, hr;
    int   n;
    n = 0;
    hr = 1'h0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!hr && n < 64)
    begin
      @(negedge clk);
      n++;
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      rd_val = s_axi_rdata;
      sm_val = sm_rdata;
      rsp = s_axi_rresp;
      @(posedge clk);
      if (ha) s_axi_arvalid <= 1'h0;
      if (hr) s_axi_rready <= 1'h0;
    end
    chk("read answer", 32'h1, {31'h0, hr});
  endtask

  task automatic rc(input string what, input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(what, {24'h0, e}, rd_val);
  endtask

  // requests are registered, so allow two edges after the cause
  task automatic irq(input string what, input logic h, input logic l);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(what, {30'h0, h, l}, {30'h0, irq_high, irq_low});
    chk({what, " small"}, {30'h0, h, l}, {30'h0, sm_irq_high, sm_irq_low});
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    repeat (20) @(posedge clk);
    resetn <= 1'h1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < NUM_REGS; i++)
    begin
      rc("flag reset", FLAG_BASE + 8'(4 * i), FLAG_RST); // reset value
      rc("enable reset", EN_BASE + 8'(4 * i), EN_RST); // reset value
      rc("prio reset", PRIO_BASE + 8'(4 * i), PRIO_RST & IMPL_FULL[i * 8 +: 8]); // reset value
    end
    rc("control reset", CTRL_ADDR, {5'h0, CTRL_RST}); // reset value
    evt_flags <= {NUM_REGS{8'hFF}};
    @(posedge clk);
    evt_flags <= 48'h0;
    for (int i = 0; i < NUM_REGS; i++)
    begin
      rc("event set", FLAG_BASE + 8'(4 * i), IMPL_FULL[i * 8 +: 8] & ~RO_MASK[i * 8 +: 8]); // enables off
      chk("small event set", {24'h0, IMPL_SMALL[i * 8 +: 8] & ~RO_MASK[i * 8 +: 8]}, sm_val);
      wr(FLAG_BASE + 8'(4 * i), 8'h00);
      rc("write clear", FLAG_BASE + 8'(4 * i), 8'h00);
      wr(FLAG_BASE + 8'(4 * i), 8'hFF);
      rc("write set", FLAG_BASE + 8'(4 * i), IMPL_FULL[i * 8 +: 8] & ~RO_MASK[i * 8 +: 8]);
      wr(FLAG_BASE + 8'(4 * i), 8'h00);
    end
    serial1_rx_full <= 1'h1;
    serial2_tx_empty <= 1'h1;
    wr(FLAG_BASE, 8'h00);
    rc("rx1 mirror", FLAG_BASE, 8'h20); // write ignored
    rc("tx2 mirror", FLAG_BASE + 8'h08, 8'h10);
    serial1_rx_full <= 1'h0;
    serial2_tx_empty <= 1'h0;
    serial1_tx_empty <= 1'h1;
    serial2_rx_full <= 1'h1;
    rc("tx1 mirror", FLAG_BASE, 8'h10);
    rc("rx2 mirror", FLAG_BASE + 8'h08, 8'h20);
    serial1_tx_empty <= 1'h0;
    serial2_rx_full <= 1'h0;
    rc("mirror idle", FLAG_BASE, 8'h00); // ports drop the levels
    fork
      wr(FLAG_BASE + 8'h04, 8'h00);
      begin
        @(negedge clk iff (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready));
        // the store lands one edge after the handshake; the event must meet it there
        @(posedge clk);
        evt_flags[1][2] <= 1'h1;
        @(posedge clk);
        evt_flags[1][2] <= 1'h0;
      end
    join
    rc("set wins", FLAG_BASE + 8'h04, 8'h04); // event at the store edge
    wr(EN_BASE + 8'h04, 8'h04);
    irq("all off", 1'h0, 1'h0);
    wr(CTRL_ADDR, 8'h03);
    irq("compat on", 1'h1, 1'h0);
    wr(CTRL_ADDR, 8'h01);
    irq("group off", 1'h0, 1'h0);
    wr(CTRL_ADDR, 8'h02);
    irq("global off", 1'h0, 1'h0);
    wr(CTRL_ADDR, 8'h07);
    irq("prio high", 1'h1, 1'h0);
    wr(PRIO_BASE + 8'h04, 8'h00);
    irq("prio low", 1'h0, 1'h1);
    wr(FLAG_BASE + 8'h04, 8'h00);
    irq("serviced", 1'h0, 1'h0);
    rd(8'h4C);
    chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    chk("unmapped rdata", 32'h0, rd_val);
    rd(8'h01);
    chk("misaligned rresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    wr(8'h4C, 8'hFF);
    chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    wr(FLAG_BASE + 8'h10, 8'hFF, 4'h0);
    chk("no strobe bresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
    rc("no strobe store", FLAG_BASE + 8'h10, 8'h00);
    final_report();
  end

  initial
  begin
    #200000;
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire
